// >>> hdl/pfci_pkg.sv
// Purpose: constants for the parallel flash host controller
// Assumes: 200 MHz ref_clk, byte-wide flash with 17 address lines
// Notes: all command codes and strobe timings live here
// Notes on behaviour
// - a write needs device select and write strobe both low
// - erase the sector before programming; programming is one byte at a time
// - byte program is the three guard writes then address and data
// - on an odd status read, read twice more; two valid reads mean done
// - chip erase is six writes ending with code 10 at address 5555
// - guard writes: AA to 5555, 55 to 2AAA, A0 to 5555
package pfci_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam logic [16:0] CMD_ADDR_A = 17'h05555;
   localparam logic [16:0] CMD_ADDR_B = 17'h02AAA;
   localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
   localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
   localparam logic [7:0] CODE_PROGRAM = 8'hA0;
   localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CODE_CHIP_ERASE = 8'h10;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam int POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int CLK_PERIOD_PS = 5000;
   // strobe phase timings in ns: setup, pulse width, read access, hold/recovery; then the program busy limit
   localparam int T_SETUP_NS = 10;
   localparam int T_PULSE_NS = 40;
   localparam int T_READ_NS = 90;
   localparam int T_HOLD_NS = 20;
   localparam int T_PROG_MAX_NS = 16000;
   localparam int CYC_SETUP = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CYC_PULSE = (T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CYC_READ = (T_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CYC_HOLD = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CYC_PROG_MAX = (T_PROG_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int SYNC_N = 3;
   // wide enough for the default erase limit without wrapping
   localparam int CNT_W = 26;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_PROGRAM = 2'h1;
   localparam logic [1:0] OP_CHIP_ERASE = 2'h2;
   localparam logic [1:0] RES_OK = 2'h0;
   localparam logic [1:0] RES_TIMEOUT = 2'h1;
   localparam logic [1:0] RES_VERIFY = 2'h2;
endpackage

// >>> hdl/pfci_host.sv
// Purpose: host-side controller that drives the flash strobe pins
// Assumes: single ref_clk domain; flash data lines sampled through three flops
// Notes: one request at a time; req is taken only while ready is high
`timescale 1ns/1ps
module pfci_host #(
   parameter int PROG_TIMEOUT = pfci_pkg::CYC_PROG_MAX,
   parameter int ERASE_TIMEOUT = 40000000
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req,
   input wire logic [1:0] req_op,
   input wire logic [pfci_pkg::ADDR_W-1:0] req_addr,
   input wire logic [pfci_pkg::DATA_W-1:0] req_data,
   output logic ready,
   output logic done,
   output logic [1:0] result,
   output logic [pfci_pkg::DATA_W-1:0] rd_data,
   output logic device_select_n,
   output logic output_gate_n,
   output logic write_strobe_n,
   output logic [pfci_pkg::ADDR_W-1:0] address_lines,
   output logic [pfci_pkg::DATA_W-1:0] data_lines_o,
   output logic data_lines_oe_n,
   input wire logic [pfci_pkg::DATA_W-1:0] data_lines_i
);
   import pfci_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_W_SETUP, ST_W_PULSE, ST_W_HOLD,
      ST_R_SETUP, ST_R_WAIT, ST_R_HOLD, ST_EVAL, ST_DONE
   } pfci_state_e;

   typedef struct packed {
      pfci_state_e st;
      logic [2:0] step;
      logic [1:0] op;
      logic [ADDR_W-1:0] tgt_addr;
      logic [DATA_W-1:0] tgt_data;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] busy_cnt;
      logic polling;
      logic have_prev;
      logic [DATA_W-1:0] prev;
      logic [1:0] confirm;
      logic ready;
      logic done;
      logic [1:0] result;
      logic [DATA_W-1:0] rd_data;
      logic sel_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic dq_oe_n;
      logic [DATA_W-1:0] s1;
      logic [DATA_W-1:0] s2;
      logic [DATA_W-1:0] s3;
   } pfci_regs_s;

   pfci_regs_s cur_ff;
   pfci_regs_s nxt_ff;
   logic [ADDR_W-1:0] seq_addr;
   logic [DATA_W-1:0] seq_data;
   logic [2:0] seq_len;
   logic [DATA_W-1:0] sample;
   logic stable;
   logic [CNT_W-1:0] limit;

   // command sequence table; byte program = 4 writes, chip erase = 6
   always_comb begin
      seq_addr = CMD_ADDR_A;
      seq_data = CODE_UNLOCK1;
      unique case (cur_ff.step)
         3'h0: begin
            seq_addr = CMD_ADDR_A;
            seq_data = CODE_UNLOCK1;
         end
         3'h1, 3'h4: begin
            seq_addr = CMD_ADDR_B;
            seq_data = CODE_UNLOCK2;
         end
         3'h2: begin
            seq_addr = CMD_ADDR_A;
            seq_data = (cur_ff.op == OP_PROGRAM) ? CODE_PROGRAM : CODE_ERASE_SETUP;
         end
         3'h3: begin
            seq_addr = (cur_ff.op == OP_PROGRAM) ? cur_ff.tgt_addr : CMD_ADDR_A;
            seq_data = (cur_ff.op == OP_PROGRAM) ? cur_ff.tgt_data : CODE_UNLOCK1;
         end
         default: begin
            seq_addr = CMD_ADDR_A;
            seq_data = CODE_CHIP_ERASE;
         end
      endcase
   end

   assign seq_len = (cur_ff.op == OP_PROGRAM) ? 3'h4 : 3'h6;
   // a byte counts once the second and third flops agree on every bit
   assign stable = (cur_ff.s2 == cur_ff.s3);
   assign sample = cur_ff.s3;
   assign limit = (cur_ff.op == OP_PROGRAM) ? CNT_W'(PROG_TIMEOUT) : CNT_W'(ERASE_TIMEOUT);

   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.done = 1'b0;
      nxt_ff.s1 = data_lines_i;
      nxt_ff.s2 = cur_ff.s1;
      nxt_ff.s3 = cur_ff.s2;
      if (cur_ff.polling && cur_ff.busy_cnt != {CNT_W{1'b1}}) begin
         nxt_ff.busy_cnt = cur_ff.busy_cnt + 1'b1;
      end
      unique case (cur_ff.st)
         ST_IDLE: begin
            nxt_ff.sel_n = 1'b1;
            nxt_ff.oe_n = 1'b1;
            nxt_ff.we_n = 1'b1;
            nxt_ff.dq_oe_n = 1'b1;
            if (req) begin
               nxt_ff.ready = 1'b0;
               nxt_ff.op = req_op;
               nxt_ff.tgt_addr = req_addr;
               nxt_ff.tgt_data = (req_op == OP_CHIP_ERASE) ? ERASED_BYTE : req_data;
               nxt_ff.step = 3'h0;
               nxt_ff.polling = 1'b0;
               nxt_ff.have_prev = 1'b0;
               nxt_ff.confirm = 2'h0;
               nxt_ff.busy_cnt = '0;
               nxt_ff.cnt = '0;
               nxt_ff.st = (req_op == OP_READ) ? ST_R_SETUP : ST_W_SETUP;
            end
         end
         ST_W_SETUP: begin
            // output gate stays high so the flash never inhibits the write
            nxt_ff.oe_n = 1'b1;
            nxt_ff.sel_n = 1'b0;
            nxt_ff.addr = seq_addr;
            nxt_ff.dout = seq_data;
            nxt_ff.dq_oe_n = 1'b0;
            nxt_ff.cnt = cur_ff.cnt + 1'b1;
            if (cur_ff.cnt >= CNT_W'(CYC_SETUP - 1)) begin
               nxt_ff.cnt = '0;
               nxt_ff.we_n = 1'b0;
               nxt_ff.st = ST_W_PULSE;
            end
         end
         ST_W_PULSE: begin
            nxt_ff.cnt = cur_ff.cnt + 1'b1;
            if (cur_ff.cnt >= CNT_W'(CYC_PULSE - 1)) begin
               // strobe rises before select, so it is the data edge
               nxt_ff.cnt = '0;
               nxt_ff.we_n = 1'b1;
               nxt_ff.st = ST_W_HOLD;
            end
         end
         ST_W_HOLD: begin
            nxt_ff.cnt = cur_ff.cnt + 1'b1;
            if (cur_ff.cnt >= CNT_W'(CYC_HOLD - 1)) begin
               nxt_ff.cnt = '0;
               nxt_ff.sel_n = 1'b1;
               nxt_ff.dq_oe_n = 1'b1;
               if (cur_ff.step == seq_len - 3'h1) begin
                  nxt_ff.polling = 1'b1;
                  nxt_ff.busy_cnt = '0;
                  nxt_ff.st = ST_R_SETUP;
               end else begin
                  nxt_ff.step = cur_ff.step + 3'h1;
                  nxt_ff.st = ST_W_SETUP;
               end
            end
         end
         ST_R_SETUP: begin
            nxt_ff.dq_oe_n = 1'b1;
            nxt_ff.sel_n = 1'b0;
            nxt_ff.oe_n = 1'b0;
            nxt_ff.addr = cur_ff.tgt_addr;
            nxt_ff.cnt = '0;
            nxt_ff.st = ST_R_WAIT;
         end
         ST_R_WAIT: begin
            // wait covers access time plus the three-flop input delay
            nxt_ff.cnt = cur_ff.cnt + 1'b1;
            if (cur_ff.cnt >= CNT_W'(CYC_READ + SYNC_N) && stable) begin
               nxt_ff.rd_data = sample;
               nxt_ff.cnt = '0;
               nxt_ff.oe_n = 1'b1;
               nxt_ff.sel_n = 1'b1;
               nxt_ff.st = ST_R_HOLD;
            end
         end
         ST_R_HOLD: begin
            nxt_ff.cnt = cur_ff.cnt + 1'b1;
            if (cur_ff.cnt >= CNT_W'(CYC_HOLD - 1)) begin
               nxt_ff.cnt = '0;
               nxt_ff.st = cur_ff.polling ? ST_EVAL : ST_DONE;
               nxt_ff.result = RES_OK;
            end
         end
         ST_EVAL: begin
            nxt_ff.have_prev = 1'b1;
            nxt_ff.prev = cur_ff.rd_data;
            nxt_ff.st = ST_R_SETUP;
            // busy: toggle bit moved or poll bit not yet the true value
            if ((cur_ff.have_prev && cur_ff.prev[TOGGLE_BIT] != cur_ff.rd_data[TOGGLE_BIT]) ||
                cur_ff.rd_data[POLL_BIT] != cur_ff.tgt_data[POLL_BIT]) begin
               nxt_ff.confirm = 2'h0;
               if (cur_ff.busy_cnt >= limit) begin
                  nxt_ff.result = RES_TIMEOUT;
                  nxt_ff.polling = 1'b0;
                  nxt_ff.st = ST_DONE;
               end
            end else if (cur_ff.confirm == 2'h2) begin
               // two further matching reads confirm the end of the write
               nxt_ff.polling = 1'b0;
               nxt_ff.result = (cur_ff.rd_data == cur_ff.tgt_data) ? RES_OK : RES_VERIFY;
               nxt_ff.st = ST_DONE;
            end else begin
               nxt_ff.confirm = cur_ff.confirm + 2'h1;
            end
         end
         ST_DONE: begin
            // no command is issued while busy unless polling timed out; the flash would drop it
            nxt_ff.done = 1'b1;
            nxt_ff.ready = 1'b1;
            nxt_ff.st = ST_IDLE;
         end
         default: nxt_ff.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cur_ff <= '{st: ST_IDLE, ready: 1'b1, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                     dq_oe_n: 1'b1, default: '0};
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   assign ready = cur_ff.ready;
   assign done = cur_ff.done;
   assign result = cur_ff.result;
   assign rd_data = cur_ff.rd_data;
   assign device_select_n = cur_ff.sel_n;
   assign output_gate_n = cur_ff.oe_n;
   assign write_strobe_n = cur_ff.we_n;
   assign address_lines = cur_ff.addr;
   assign data_lines_o = cur_ff.dout;
   assign data_lines_oe_n = cur_ff.dq_oe_n;
endmodule

// >>> testbench/pfci_host_sva.sv
// Purpose: pin protocol checks for pfci_host
// Assumes: one clock domain, package cycle counts
// Notes: watches the design's own outputs and its req input
`timescale 1ns/1ps
module pfci_host_sva (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req,
   input wire logic ready,
   input wire logic done,
   input wire logic device_select_n,
   input wire logic output_gate_n,
   input wire logic write_strobe_n,
   input wire logic [16:0] address_lines,
   input wire logic [7:0] data_lines_o,
   input wire logic data_lines_oe_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_wr_sel;
      !write_strobe_n |-> !device_select_n && output_gate_n;
   endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("strobe low without select");
   property p_no_clash;
      !output_gate_n |-> data_lines_oe_n;
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("host drives during read");
   property p_pulse;
      $fell(write_strobe_n) |-> !write_strobe_n [*8] ##1 write_strobe_n;
   endproperty
   a_pulse: assert property (p_pulse) else $error("strobe pulse width wrong");
   property p_setup;
      $fell(write_strobe_n) |-> !$past(device_select_n) && !data_lines_oe_n;
   endproperty
   a_setup: assert property (p_setup) else $error("no setup before strobe");
   property p_stable;
      !write_strobe_n && $past(!write_strobe_n) |-> $stable(address_lines) && $stable(data_lines_o);
   endproperty
   a_stable: assert property (p_stable) else $error("bus moved in strobe");
   property p_hold;
      $rose(write_strobe_n) |-> (!device_select_n && !data_lines_oe_n && $stable(data_lines_o)) [*3];
   endproperty
   a_hold: assert property (p_hold) else $error("data not held after strobe");
   property p_idle;
      ready && !req |-> device_select_n && write_strobe_n;
   endproperty
   a_idle: assert property (p_idle) else $error("idle but selected");
   property p_done;
      done |-> ready ##1 !done;
   endproperty
   a_done: assert property (p_done) else $error("done not a pulse");
   property p_take;
      ready && req |=> !ready;
   endproperty
   a_take: assert property (p_take) else $error("request not taken");
   c_write: cover property ($fell(write_strobe_n));
   c_read: cover property ($fell(output_gate_n));
   c_done: cover property (done);
endmodule

// >>> testbench/pfci_flash_model.sv
// Purpose: behavioural byte-wide flash for the host bench
// Assumes: busy_ns set by the bench before each program or erase
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ps
module pfci_flash_model (
   input wire logic device_select_n,
   input wire logic output_gate_n,
   input wire logic write_strobe_n,
   input wire logic [16:0] address_lines,
   input wire logic [7:0] data_lines_o,
   input wire logic [31:0] busy_ns,
   output logic [7:0] data_lines_i
);
   logic [7:0] mem [0:131071];
   logic [16:0] la, pa;
   logic [7:0] pd, q;
   logic wr_on = 0, busy = 0, er = 0, tog = 0;
   int st = 0;
   wire rd = !device_select_n && !output_gate_n;
   assign data_lines_i = q;
   initial for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'h5A;
   function automatic bit cmd(input logic [15:0] a, input logic [7:0] d);
      return la[15:0] == a && data_lines_o == d;
   endfunction
   // later falling edge opens a write; gate low inhibits it
   always @(negedge write_strobe_n or negedge device_select_n)
      if (!write_strobe_n && !device_select_n && output_gate_n) begin
         la = address_lines;
         wr_on = 1;
      end
   // earlier rising edge takes the data; anything while busy is dropped
   always @(posedge write_strobe_n or posedge device_select_n)
      if (wr_on) begin
         wr_on = 0;
         if (!busy) begin
            if (st == 3) begin
               pa = la;
               pd = mem[la] & data_lines_o;
               er = 0;
               busy = 1;
               st = 0;
            end else if (st == 6 && cmd(16'h5555, 8'h10)) begin
               er = 1;
               busy = 1;
               st = 0;
            end else if ((st == 0 || st == 4) && cmd(16'h5555, 8'hAA)) st = st + 1;
            else if ((st == 1 || st == 5) && cmd(16'h2AAA, 8'h55)) st = st + 1;
            else if (st == 2 && cmd(16'h5555, 8'hA0)) st = 3;
            else if (st == 2 && cmd(16'h5555, 8'h80)) st = 4;
            else st = 0;
         end
      end
   always @(posedge busy) begin
      #(busy_ns);
      if (er) for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
      else mem[pa] = pd;
      busy = 0;
   end
   always @* if (rd) q = busy ? {er ? 1'b0 : ~pd[7], tog, 6'h15} : mem[address_lines];
   always @(negedge rd) begin
      q = ~q;
      if (busy) tog = ~tog;
   end
endmodule

// >>> testbench/tb_pfci_host.sv
// Purpose: self-checking bench for pfci_host against a flash model
// Assumes: timeouts shortened to 200 and 2000 cycles
// Notes: every operation also sends one request that must be ignored
`timescale 1ns/1ps
module tb_pfci_host;
   import pfci_pkg::*;
   logic ref_clk = 0, rst = 1, req = 0;
   logic [1:0] req_op = 0, result;
   logic [16:0] req_addr = 0, address_lines;
   logic [7:0] req_data = 0, rd_data, data_lines_o, data_lines_i;
   logic ready, done, device_select_n, output_gate_n, write_strobe_n, data_lines_oe_n;
   logic [31:0] busy_ns = 300;
   int n_mismatch = 0, compares = 0;
   always #2.5 ref_clk = ~ref_clk;
   pfci_host #(.PROG_TIMEOUT(200), .ERASE_TIMEOUT(2000)) u_pfci_host (.ref_clk(ref_clk), .rst(rst),
      .req(req), .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .ready(ready), .done(done),
      .result(result), .rd_data(rd_data), .device_select_n(device_select_n), .output_gate_n(output_gate_n),
      .write_strobe_n(write_strobe_n), .address_lines(address_lines), .data_lines_o(data_lines_o),
      .data_lines_oe_n(data_lines_oe_n), .data_lines_i(data_lines_i));
   pfci_flash_model u_pfci_flash_model (.device_select_n(device_select_n), .output_gate_n(output_gate_n),
      .write_strobe_n(write_strobe_n), .address_lines(address_lines), .data_lines_o(data_lines_o),
      .busy_ns(busy_ns), .data_lines_i(data_lines_i));
   task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("mismatches=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic do_op(input logic [1:0] op, input logic [16:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      req <= 1;
      req_op <= op;
      req_addr <= a;
      req_data <= d;
      @(posedge ref_clk);
      req <= 0;
      repeat (3) @(posedge ref_clk);
      // a second request while busy must leave no trace
      req <= 1;
      req_op <= OP_READ;
      @(posedge ref_clk);
      req <= 0;
      @(negedge ref_clk);
      chk(17'(ready), 17'h0);
      while (done !== 1'b1 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      // a loop that runs out counts as a mismatch here
      chk(17'(done), 17'h1);
   endtask
   task automatic t_read(input logic [16:0] a, input logic [7:0] exp);
      do_op(OP_READ, a, 8'h00);
      chk(17'(result), 17'(RES_OK));
      chk(17'(rd_data), 17'(exp));
   endtask
   task automatic t_erase();
      busy_ns = 2000;
      do_op(OP_CHIP_ERASE, 17'h1ABCD, 8'h00);
      chk(17'(result), 17'(RES_OK));
      t_read(17'h1ABCD, ERASED_BYTE);
      t_read(17'h00000, ERASED_BYTE);
   endtask
   task automatic t_prog(input logic [16:0] a, input logic [7:0] d, input logic [31:0] ns, input logic [1:0] res);
      busy_ns = ns;
      do_op(OP_PROGRAM, a, d);
      chk(17'(result), 17'(res));
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 0;
      @(negedge ref_clk);
      chk(17'({ready, device_select_n, write_strobe_n, output_gate_n, data_lines_oe_n, done}), 17'h3E);
      t_read(17'h1ABCD, 8'h97);
      t_erase();
      t_prog(17'h1F00F, 8'h3C, 300, RES_OK);
      t_read(17'h1F00F, 8'h3C);
      t_prog(17'h1F00F, 8'h41, 300, RES_VERIFY);
      t_prog(17'h00100, 8'h00, 5000, RES_TIMEOUT);
      report_and_stop();
   end
   initial begin
      repeat (50000) @(posedge ref_clk);
      n_mismatch++;
      report_and_stop();
   end
endmodule
bind pfci_host pfci_host_sva u_pfci_host_sva (.ref_clk(ref_clk), .rst(rst), .req(req), .ready(ready),
   .done(done), .device_select_n(device_select_n), .output_gate_n(output_gate_n),
   .write_strobe_n(write_strobe_n), .address_lines(address_lines), .data_lines_o(data_lines_o),
   .data_lines_oe_n(data_lines_oe_n));
